// [core/pcr_pkg.sv]
// constants for the clock-generator configuration register bank
// assumes a 100 MHz system clock that samples the serial link pins
package pcr_pkg;

  localparam int          CFG_BYTES     = 8;
  localparam int          PTR_W         = 3;
  localparam int          ADDR_SEL_W    = 2;
  localparam int          WORD_W        = 64;

  // upper five bits of the serial device address; value is arbitrary
  localparam logic [4:0]  DEV_ADDR_HI   = 5'h0b;

  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [3:0]  POST_AB_MAX   = 4'hb;

  // byte offsets
  localparam logic [2:0]  REG_REF_DIV_LOW          = 3'h0;
  localparam logic [2:0]  REG_POST_C_CTRL_REF_HIGH = 3'h1;
  localparam logic [2:0]  REG_POST_STAGE_AB        = 3'h2;
  localparam logic [2:0]  REG_FB_DIV_LOW           = 3'h3;
  localparam logic [2:0]  REG_FB_DIV_HIGH_OUT_CTRL = 3'h4;
  localparam logic [2:0]  REG_LOOP_TUNING          = 3'h5;
  localparam logic [2:0]  REG_POWER_SYNC_CTRL      = 3'h6;
  localparam logic [2:0]  REG_SPARE_RESERVED       = 3'h7;

  // field positions within the 64-bit configuration word
  localparam int          REF_DIV_MSB   = 11;
  localparam int          REF_DIV_LSB   = 0;
  localparam int          REF_SRC_BIT   = 12;
  localparam int          PD_A_BIT      = 13;
  localparam int          POST_C_MSB    = 15;
  localparam int          POST_C_LSB    = 14;
  localparam int          POST_A_MSB    = 19;
  localparam int          POST_A_LSB    = 16;
  localparam int          POST_B_MSB    = 23;
  localparam int          POST_B_LSB    = 20;
  localparam int          FB_DIV_MSB    = 37;
  localparam int          FB_DIV_LSB    = 24;
  localparam int          FB_SRC_BIT    = 38;
  localparam int          OUT_STYLE_BIT = 39;
  localparam int          PUMP_MSB      = 41;
  localparam int          PUMP_LSB      = 40;
  localparam int          LRES_MSB      = 45;
  localparam int          LRES_LSB      = 44;
  localparam int          LCAP_BIT      = 46;
  localparam int          SYNC_ON_BIT   = 48;
  localparam int          SYNC_EDGE_BIT = 49;
  localparam int          PD_B_BIT      = 53;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } pcr_state_t;

endpackage

// [core/pcr_bank.sv]
// configuration register bank with its serial slave port and sync gate
// assumes scl/sda/addr/sync pins are asynchronous and sampled at 100 MHz
`timescale 1ns/100ps
`default_nettype none

// Function
// [RL1] bit 12 picks crystal (0) or reference pin (1) for reference divider
// [RL2] bit 38 feeds feedback divider from oscillator (0) or post chain (1)
// [RL3] bits 13 and 53 each power down their circuitry when set
// [RL4] bit 39 selects differential (0) or single-ended (1) output drivers
// [RL5] pump current 41:40, loop resistor 45:44, loop cap 46 are static controls
// [RL6] reference divisor is unsigned bits 11:0, bit 0 weight one
// [RL7] feedback divisor is unsigned bits 37:24, bit 37 weight 8192
// [RL8] bit 48 enables the sync input when set
// [RL9] bit 49 chooses falling (0) or rising (1) sync edge
// [RL10] host writes zero to all reserved bits
// [RL11] post stages a and b divide by code plus one, codes 0 to 11
// [RL12] post stage c divides by 1, 2, 4 or 8
// [RL13] all bits clear at reset and read back as written
// [RL14] each byte updates when its data byte is acknowledged
// [RL15] three-bit byte pointer selects bytes 0 to 7 of the word
// [RL16] fields spanning two bytes follow each byte as it updates
module pcr_bank (
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_n_o,
  input  wire logic [pcr_pkg::ADDR_SEL_W-1:0]  addr_sel_i,
  input  wire logic                            sync_i,
  output logic                                 sync_event_o,
  output logic [11:0]                          ref_divisor_o,
  output logic                                 ref_div_source_sel_o,
  output logic                                 power_down_a_o,
  output logic [1:0]                           post_stage_c_o,
  output logic [3:0]                           post_c_modulus_o,
  output logic [3:0]                           post_stage_a_o,
  output logic [4:0]                           post_a_modulus_o,
  output logic [3:0]                           post_stage_b_o,
  output logic [4:0]                           post_b_modulus_o,
  output logic [13:0]                          fb_divisor_o,
  output logic                                 fb_div_source_sel_o,
  output logic                                 output_style_sel_o,
  output logic [1:0]                           pump_current_sel_o,
  output logic [1:0]                           loop_resistor_sel_o,
  output logic                                 loop_cap_sel_o,
  output logic                                 sync_gate_on_o,
  output logic                                 sync_edge_sel_o,
  output logic                                 power_down_b_o
);
  import pcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [4:0] post_ab_mod(input logic [3:0] code);
    post_ab_mod = {1'b0, code} + 5'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic                  scl_m_q, scl_s_q, scl_p_q;
  logic                  sda_m_q, sda_s_q, sda_p_q;
  logic                  syn_m_q, syn_s_q, syn_p_q;
  logic [ADDR_SEL_W-1:0] adr_m_q, adr_s_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      syn_m_q <= 1'b0;
      syn_s_q <= 1'b0;
      syn_p_q <= 1'b0;
      adr_m_q <= '0;
      adr_s_q <= '0;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      syn_m_q <= sync_i;
      syn_s_q <= syn_m_q;
      syn_p_q <= syn_s_q;
      adr_m_q <= addr_sel_i;
      adr_s_q <= adr_m_q;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c, syn_rise, syn_fall;

  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_c  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_c   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign syn_rise = syn_s_q & ~syn_p_q;
  assign syn_fall = ~syn_s_q & syn_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // serial slave and register array

  pcr_state_t        st_q, st_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [7:0]        sh_q, sh_d;
  logic [PTR_W-1:0]  ptr_q, ptr_d;
  logic              rw_q, rw_d;
  logic              drv_q, drv_d;
  logic [7:0]        cfg_q [CFG_BYTES];
  logic [7:0]        cfg_d [CFG_BYTES];
  logic [WORD_W-1:0] cfg_word;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    rw_d  = rw_q;
    drv_d = drv_q;
    cfg_d = cfg_q;
    if (start_c) begin
      st_d  = ST_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_c) begin
      st_d  = ST_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise && cnt_q != BITS_PER_BYTE) begin
            sh_d  = {sh_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            drv_d = 1'b1;
            if (st_q == ST_ADDR) begin
              if (sh_q[7:1] == {DEV_ADDR_HI, adr_s_q}) begin
                st_d = ST_ADDR_ACK;
                rw_d = sh_q[0];
              end else begin
                st_d  = ST_IDLE;
                drv_d = 1'b0;
              end
            end else if (st_q == ST_PTR) begin
              st_d  = ST_PTR_ACK;
              ptr_d = sh_q[PTR_W-1:0]; // RL15
            end else begin
              st_d         = ST_WDATA_ACK;
              cfg_d[ptr_q] = sh_q; // RL14 RL16
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              st_d  = ST_RDATA;
              sh_d  = cfg_q[ptr_q]; // RL13
              drv_d = ~cfg_q[ptr_q][7];
            end else begin
              st_d  = ST_PTR;
              drv_d = 1'b0;
            end
          end
        end
        ST_PTR_ACK: begin
          if (scl_fall) begin
            st_d  = ST_WDATA;
            drv_d = 1'b0;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            st_d  = ST_WDATA;
            drv_d = 1'b0;
            ptr_d = ptr_q + 3'h1; // RL15
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == LAST_BIT) begin
              st_d  = ST_RDATA_ACK;
              drv_d = 1'b0;
              ptr_d = ptr_q + 3'h1; // RL15
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              drv_d = ~sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise && sda_s_q) begin
            st_d = ST_IDLE;
          end else if (scl_fall) begin
            st_d  = ST_RDATA;
            cnt_d = 4'h0;
            sh_d  = cfg_q[ptr_q];
            drv_d = ~cfg_q[ptr_q][7];
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q  <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
      ptr_q <= '0;
      rw_q  <= 1'b0;
      drv_q <= 1'b0;
      for (int i = 0; i < CFG_BYTES; i++) begin
        cfg_q[i] <= CFG_RESET; // RL13
      end
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      ptr_q <= ptr_d;
      rw_q  <= rw_d;
      drv_q <= drv_d;
      cfg_q <= cfg_d;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~drv_q;
  assign cfg_word   = {cfg_q[7], cfg_q[6], cfg_q[5], cfg_q[4],
                       cfg_q[3], cfg_q[2], cfg_q[1], cfg_q[0]};

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls

  assign ref_divisor_o        = cfg_word[REF_DIV_MSB:REF_DIV_LSB]; // RL6 RL16
  assign ref_div_source_sel_o = cfg_word[REF_SRC_BIT]; // RL1
  assign power_down_a_o       = cfg_word[PD_A_BIT]; // RL3
  assign post_stage_c_o       = cfg_word[POST_C_MSB:POST_C_LSB];
  assign post_c_modulus_o     = 4'h1 << post_stage_c_o; // RL12
  assign post_stage_a_o       = cfg_word[POST_A_MSB:POST_A_LSB];
  assign post_a_modulus_o     = post_ab_mod(post_stage_a_o); // RL11
  assign post_stage_b_o       = cfg_word[POST_B_MSB:POST_B_LSB];
  assign post_b_modulus_o     = post_ab_mod(post_stage_b_o); // RL11
  assign fb_divisor_o         = cfg_word[FB_DIV_MSB:FB_DIV_LSB]; // RL7 RL16
  assign fb_div_source_sel_o  = cfg_word[FB_SRC_BIT]; // RL2
  assign output_style_sel_o   = cfg_word[OUT_STYLE_BIT]; // RL4
  assign pump_current_sel_o   = cfg_word[PUMP_MSB:PUMP_LSB]; // RL5
  assign loop_resistor_sel_o  = cfg_word[LRES_MSB:LRES_LSB]; // RL5
  assign loop_cap_sel_o       = cfg_word[LCAP_BIT]; // RL5
  assign sync_gate_on_o       = cfg_word[SYNC_ON_BIT];
  assign sync_edge_sel_o      = cfg_word[SYNC_EDGE_BIT];
  assign power_down_b_o       = cfg_word[PD_B_BIT]; // RL3

  ////////////////////////////////////////////////////////////////////////////
  // sync input gate

  logic sev_q, sev_d;

  always_comb begin
    sev_d = sync_gate_on_o & (sync_edge_sel_o ? syn_rise : syn_fall); // RL8 RL9
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sev_q <= 1'b0;
    end else begin
      sev_q <= sev_d;
    end
  end

  assign sync_event_o = sev_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_data_acked;
    st_q == ST_WDATA && scl_fall && cnt_q == BITS_PER_BYTE && !start_c && !stop_c;
  endsequence

  sequence s_read_enter;
    st_q == ST_ADDR_ACK && scl_fall && rw_q && !start_c && !stop_c;
  endsequence

  property p_reset_clear;
    $rose(rst_n_i) |-> cfg_word == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("bank not clear after reset"); // RL13

  property p_wr_on_ack;
    s_data_acked |=> st_q == ST_WDATA_ACK && !sda_oe_n_o
                     && cfg_q[$past(ptr_q)] == $past(sh_q);
  endproperty
  a_wr_on_ack: assert property (p_wr_on_ack) else $error("byte not stored at ack"); // RL14

  property p_rd_load;
    s_read_enter |=> st_q == ST_RDATA && sh_q == cfg_q[ptr_q]
                     && sda_oe_n_o == cfg_q[ptr_q][7];
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("read byte not loaded"); // RL15

  property p_byte0_only;
    s_data_acked ##0 (ptr_q == REG_REF_DIV_LOW)
      |=> ref_divisor_o[11:8] == $past(ref_divisor_o[11:8]);
  endproperty
  a_byte0_only: assert property (p_byte0_only) else $error("upper divisor moved"); // RL16

  property p_post_a;
    post_stage_a_o <= POST_AB_MAX |-> post_a_modulus_o == {1'b0, post_stage_a_o} + 5'h01;
  endproperty
  a_post_a: assert property (p_post_a) else $error("post a modulus wrong"); // RL11

  property p_post_c;
    (post_stage_c_o == 2'h3) |-> post_c_modulus_o == 4'h8;
  endproperty
  a_post_c: assert property (p_post_c) else $error("post c modulus wrong"); // RL12

  property p_sync_edge;
    sync_event_o |-> $past(sync_gate_on_o)
                     && ($past(sync_edge_sel_o) ? $past(syn_rise) : $past(syn_fall));
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("sync event on wrong edge"); // RL9

  property p_sync_off;
    !sync_gate_on_o |=> !sync_event_o;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync event while disabled"); // RL8

endmodule

`default_nettype wire

// [tb/pcr_host.sv]
// serial bus master model driving the configuration bank's link pins
// assumes a pulled-up data line resolved by the bench, 80 ns link clock
`timescale 1ns/100ps
`default_nettype none
module pcr_host (
  input  wire logic clk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_drv_o
);
  initial begin
    scl_o = 1'b1;
    sda_drv_o = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // start or repeated start, link clock left low
  task automatic start_cond();
    tick(2);
    sda_drv_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_drv_o = 1'b0;
    tick(4);
    scl_o = 1'b0;
  endtask
  // link clock then stands high while idle
  task automatic stop_cond();
    tick(2);
    sda_drv_o = 1'b0;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_drv_o = 1'b1;
    tick(4);
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    tick(2);
    sda_drv_o = b;
    tick(2);
    scl_o = 1'b1;
    tick(2);
    r = sda_line_i;
    tick(2);
    scl_o = 1'b0;
  endtask
  // msb first, ninth bit driven with ack_in and sampled into ack
  task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r[i]);
    xfer_bit(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// [tb/pcr_bank_tb.sv]
// self-checking bench for the configuration register bank
// assumes the host model drives the link; pull-up on the data line
`timescale 1ns/100ps
`default_nettype none
module pcr_bank_tb;
  import pcr_pkg::*;
  typedef struct {logic [2:0] p; logic [7:0] d; logic [4:0] m;} pcr_row_t;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, sync_i = 1'b0;
  logic [1:0]  addr_sel_i = 2'h2;
  logic        scl, host_sda, sda_line, sda_o, sda_oe_n, sev;
  logic [11:0] ref_div;
  logic [13:0] fb_div;
  logic [3:0]  pst_a, pst_b, mod_c;
  logic [4:0]  mod_a, mod_b;
  logic [1:0]  pst_c, pump, lres;
  logic        ref_src, pd_a, fb_src, style, lcap, s_on, s_edge, pd_b;
  logic [63:0] obs, exp_q;
  int          failures = 0, total_checks = 0;
  // pointer, data byte, expected post a modulus after the write
  pcr_row_t    rows[13] = '{'{3'h0, 8'h5a, 5'h01}, '{3'h1, 8'h9f, 5'h01},
    '{3'h1, 8'h6a, 5'h01}, '{3'h1, 8'hc5, 5'h01}, '{3'h2, 8'hb0, 5'h01},
    '{3'h2, 8'h3b, 5'h0c}, '{3'h3, 8'h81, 5'h0c}, '{3'h4, 8'ha5, 5'h0c},
    '{3'h4, 8'h6a, 5'h0c}, '{3'h5, 8'h72, 5'h0c}, '{3'h5, 8'h11, 5'h0c},
    '{3'h6, 8'h21, 5'h0c}, '{3'h7, 8'h00, 5'h0c}};
  always #5 clk_i = ~clk_i;
  assign sda_line = host_sda & (sda_oe_n | sda_o);
  assign obs = {10'h000, pd_b, 3'h0, s_edge, s_on, 1'b0, lcap, lres, 2'h0, pump, style,
                fb_src, fb_div, pst_b, pst_a, pst_c, pd_a, ref_src, ref_div};
  pcr_host host (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_drv_o(host_sda));
  pcr_bank uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_sel_i(addr_sel_i), .sync_i(sync_i),
    .sync_event_o(sev), .ref_divisor_o(ref_div), .ref_div_source_sel_o(ref_src),
    .power_down_a_o(pd_a), .post_stage_c_o(pst_c), .post_c_modulus_o(mod_c),
    .post_stage_a_o(pst_a), .post_a_modulus_o(mod_a), .post_stage_b_o(pst_b),
    .post_b_modulus_o(mod_b), .fb_divisor_o(fb_div), .fb_div_source_sel_o(fb_src),
    .output_style_sel_o(style), .pump_current_sel_o(pump),
    .loop_resistor_sel_o(lres), .loop_cap_sel_o(lcap), .sync_gate_on_o(s_on),
    .sync_edge_sel_o(s_edge), .power_down_b_o(pd_b));
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic chk_word();
    chk(obs === exp_q, "config outputs");
    chk(mod_a === {1'b0, exp_q[19:16]} + 5'h01, "post a modulus");
    chk(mod_b === {1'b0, exp_q[23:20]} + 5'h01, "post b modulus");
    chk(mod_c === 4'h1 << exp_q[15:14], "post c modulus");
  endtask
  task automatic addr_ptr(input logic [2:0] p);
    logic [7:0] r;
    logic       a;
    host.start_cond();
    host.xfer_byte({DEV_ADDR_HI, addr_sel_i, 1'b0}, 1'b1, r, a);
    chk(a === 1'b0, "address not acknowledged");
    host.xfer_byte({5'h00, p}, 1'b1, r, a);
    chk(a === 1'b0, "pointer not acknowledged");
  endtask
  // each byte checked before stop, so multi-byte fields show partial updates
  task automatic wr(input logic [2:0] p, input logic [7:0] d[$]);
    logic [7:0] r;
    logic       a;
    addr_ptr(p);
    foreach (d[i]) begin
      host.xfer_byte(d[i], 1'b1, r, a);
      chk(a === 1'b0, "data not acknowledged");
      exp_q[8*p +: 8] = d[i];
      p++;
      chk_word();
    end
    host.stop_cond();
  endtask
  task automatic rd(input logic [2:0] p, input int n);
    logic [7:0] r;
    logic       a;
    addr_ptr(p);
    host.start_cond();
    host.xfer_byte({DEV_ADDR_HI, addr_sel_i, 1'b1}, 1'b1, r, a);
    chk(a === 1'b0, "read address not acknowledged");
    for (int i = 0; i < n; i++) begin
      host.xfer_byte(8'hff, (i == n - 1), r, a);
      chk(r === exp_q[8*p +: 8], "read back");
      p++;
    end
    host.stop_cond();
  endtask
  task automatic sy(input logic lvl, input int n_exp);
    int cnt;
    cnt = 0;
    sync_i = lvl;
    repeat (8) begin
      @(negedge clk_i);
      if (sev === 1'b1) cnt++;
    end
    chk(cnt == n_exp, "sync event count");
  endtask
  task automatic chk_reset();
    exp_q = '0;
    chk_word();
    chk(sda_oe_n === 1'b1 && sev === 1'b0, "link or sync not idle");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] r;
    logic       a;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    host.tick(4);
    chk_reset();
    foreach (rows[i]) begin
      wr(rows[i].p, '{rows[i].d});
      chk(mod_a === rows[i].m, "row post a modulus");
    end
    wr(3'h6, '{8'h22, 8'h00, 8'h34, 8'h0c});
    rd(3'h5, 8);
    host.start_cond();
    host.xfer_byte({DEV_ADDR_HI, 2'h1, 1'b0}, 1'b1, r, a);
    chk(a === 1'b1, "foreign address acknowledged");
    host.xfer_byte(8'h00, 1'b1, r, a);
    host.xfer_byte(8'h77, 1'b1, r, a);
    host.stop_cond();
    chk_word();
    wr(3'h6, '{8'h03});
    sy(1'b1, 1);
    sy(1'b0, 0);
    wr(3'h6, '{8'h01});
    sy(1'b1, 0);
    sy(1'b0, 1);
    wr(3'h6, '{8'h00});
    sy(1'b1, 0);
    sy(1'b0, 0);
    wr(3'h4, '{8'hff});
    rst_n_i = 1'b0;
    host.tick(4);
    rst_n_i = 1'b1;
    host.tick(4);
    chk_reset();
    rd(3'h0, 8);
    wrap_up();
  end
endmodule
`default_nettype wire
